/* common/charger_cfg_pkg.sv */
// Types shared by the charger configuration block.
`default_nettype none
package charger_cfg_pkg;
  typedef logic [7:0]  reg_addr_t;
  typedef logic [7:0]  reg_data_t;
  typedef logic [6:0]  ilim_code_t;
  typedef logic [3:0]  foldback_code_t;
  typedef logic [11:0] ma_t;
  typedef logic [15:0] mv_t;
  typedef logic [7:0]  temp_c_t;
endpackage
`default_nettype wire

/* common/charger_cfg_regs.svh */
// Register offsets, field positions, reset values and decode constants for the charger block.
`ifndef CHARGER_CFG_REGS_SVH
`define CHARGER_CFG_REGS_SVH

`define THERMAL_ZONE_CFG_OFS    8'h1D
`define INPUT_LIMIT_CFG_OFS     8'h1E

`define ZONE_EN_BIT             7
`define FOLDBACK_MSB            6
`define FOLDBACK_LSB            3
`define VREDUCE_BIT             2
`define CHALVE_BIT              1
`define SHIP_BIT                0
`define ILIM_SPARE_BIT          7
`define ILIM_MSB                6
`define ILIM_LSB                0

`define THERMAL_ZONE_CFG_RST    8'h32
`define INPUT_LIMIT_CFG_RST     8'h95
`define UNMAPPED_READ_VAL       8'h00

`define ILIM_FLOOR_CODE         7'h04
`define ILIM_FLOOR_MA           12'h032
`define ILIM_STEP_MA            12'h019
`define CELL_COUNT              16'h0002
`define VREDUCE_PER_CELL_MV     16'h00B4
`define FOLDBACK_BASE_C         8'h55
`define FOLDBACK_STEP_C         8'h05

`endif

/* rtl/charger_thermal_input_limit_cfg.sv */
// Charger thermal-zone and input current limit configuration registers with decoded outputs.
`include "charger_cfg_regs.svh"
`default_nettype none
module charger_thermal_input_limit_cfg (
  // Clock and reset.
  input  wire logic                          clk,
  input  wire logic                          rst_b,
  // Register access from the serial control bus engine.
  input  wire logic                          reg_wr_en,
  input  wire logic                          reg_rd_en,
  input  wire charger_cfg_pkg::reg_addr_t    reg_addr,
  input  wire charger_cfg_pkg::reg_data_t    reg_wdata,
  output var  charger_cfg_pkg::reg_data_t    reg_rdata,
  output var  logic                          reg_rd_valid,
  // Charger control inputs.
  input  wire charger_cfg_pkg::mv_t          primary_termination_voltage,
  input  wire charger_cfg_pkg::ma_t          fast_charge_current_setting,
  input  wire logic                          thermistor_cool_zone,
  input  wire charger_cfg_pkg::temp_c_t      die_temp_c,
  input  wire logic                          ilim_override_valid,
  input  wire charger_cfg_pkg::ilim_code_t   ilim_override_code,
  // Decoded controls to the charger.
  output var  charger_cfg_pkg::mv_t          term_voltage_mv,
  output var  charger_cfg_pkg::ma_t          fast_charge_ma,
  output var  charger_cfg_pkg::ma_t          input_limit_ma,
  output var  logic                          factory_ship_request,
  output var  charger_cfg_pkg::temp_c_t      thermal_foldback_threshold,
  output var  logic                          thermal_regulation_flag
);
  import charger_cfg_pkg::*;

  localparam mv_t REDUCE_MV = mv_t'(`VREDUCE_PER_CELL_MV * `CELL_COUNT);

  // Register state.
  reg_data_t zone_cfg_ff;
  reg_data_t nxt_zone_cfg;
  reg_data_t ilim_cfg_ff;
  reg_data_t nxt_ilim_cfg;
  reg_data_t rdata_ff;
  reg_data_t nxt_rdata;
  logic      rd_valid_ff;
  logic      nxt_rd_valid;
  // Thermistor zone synchroniser.
  logic      cool_meta_ff;
  logic      cool_sync_ff;
  // Decoded outputs.
  mv_t       term_mv_ff;
  mv_t       nxt_term_mv;
  ma_t       fast_ma_ff;
  ma_t       nxt_fast_ma;
  ma_t       ilim_ma_ff;
  logic      ship_ff;
  logic      nxt_ship;
  temp_c_t   thresh_ff;
  temp_c_t   nxt_thresh;
  logic      thermal_regulation_flag_ff;
  logic      nxt_thermal_regulation_flag;

  ilim_code_t     eff_code;
  ma_t            eff_ma;
  logic           zone_en;
  logic           cool_active;
  foldback_code_t fold_code;
  temp_c_t        thresh_now;

  // The limit in effect may differ from the programmed code when the charger overrides it.
  assign eff_code = ilim_override_valid ? ilim_override_code
                                        : ilim_cfg_ff[`ILIM_MSB:`ILIM_LSB];
  assign zone_en     = zone_cfg_ff[`ZONE_EN_BIT];
  assign cool_active = zone_en && cool_sync_ff;
  assign fold_code   = zone_cfg_ff[`FOLDBACK_MSB:`FOLDBACK_LSB];
  assign thresh_now  = temp_c_t'(`FOLDBACK_BASE_C + {4'h0, fold_code} * `FOLDBACK_STEP_C);

  ilim_decode u_ilim_decode (
    .code     (eff_code),
    .limit_ma (eff_ma)
  );

  // Register writes and reads.
  always_comb begin
    nxt_zone_cfg = zone_cfg_ff;
    nxt_ilim_cfg = ilim_cfg_ff;
    nxt_rdata    = rdata_ff;
    nxt_rd_valid = reg_rd_en;
    if (reg_wr_en) begin
      if (reg_addr == `THERMAL_ZONE_CFG_OFS) begin
        nxt_zone_cfg = reg_wdata;
      end else if (reg_addr == `INPUT_LIMIT_CFG_OFS) begin
        nxt_ilim_cfg = reg_wdata;
      end
    end
    if (reg_rd_en) begin
      if (reg_addr == `THERMAL_ZONE_CFG_OFS) begin
        nxt_rdata = zone_cfg_ff;
      end else if (reg_addr == `INPUT_LIMIT_CFG_OFS) begin
        nxt_rdata = {ilim_cfg_ff[`ILIM_SPARE_BIT], eff_code};
      end else begin
        nxt_rdata = `UNMAPPED_READ_VAL;
      end
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      zone_cfg_ff <= `THERMAL_ZONE_CFG_RST;
      ilim_cfg_ff <= `INPUT_LIMIT_CFG_RST;
      rdata_ff    <= 8'h00;
      rd_valid_ff <= 1'b0;
    end else begin
      zone_cfg_ff <= nxt_zone_cfg;
      ilim_cfg_ff <= nxt_ilim_cfg;
      rdata_ff    <= nxt_rdata;
      rd_valid_ff <= nxt_rd_valid;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      cool_meta_ff <= 1'b0;
      cool_sync_ff <= 1'b0;
    end else begin
      cool_meta_ff <= thermistor_cool_zone;
      cool_sync_ff <= cool_meta_ff;
    end
  end

  // Charger control values.
  always_comb begin
    nxt_term_mv = primary_termination_voltage;
    nxt_fast_ma = fast_charge_current_setting;
    if (cool_active && zone_cfg_ff[`VREDUCE_BIT]) begin
      // Saturate at zero rather than wrap on a very low primary setting.
      if (primary_termination_voltage >= REDUCE_MV) begin
        nxt_term_mv = primary_termination_voltage - REDUCE_MV;
      end else begin
        nxt_term_mv = 16'h0000;
      end
    end
    if (cool_active && zone_cfg_ff[`CHALVE_BIT]) begin
      nxt_fast_ma = fast_charge_current_setting >> 1;
    end
    nxt_ship   = zone_cfg_ff[`SHIP_BIT];
    nxt_thresh = thresh_now;
    nxt_thermal_regulation_flag   = die_temp_c > thresh_now;
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      term_mv_ff <= 16'h0000;
      fast_ma_ff <= 12'h000;
      ilim_ma_ff <= `ILIM_FLOOR_MA;
      ship_ff    <= 1'b0;
      thresh_ff  <= 8'h00;
      thermal_regulation_flag_ff    <= 1'b0;
    end else begin
      term_mv_ff <= nxt_term_mv;
      fast_ma_ff <= nxt_fast_ma;
      ilim_ma_ff <= eff_ma;
      ship_ff    <= nxt_ship;
      thresh_ff  <= nxt_thresh;
      thermal_regulation_flag_ff    <= nxt_thermal_regulation_flag;
    end
  end

  assign reg_rdata                  = rdata_ff;
  assign reg_rd_valid               = rd_valid_ff;
  assign term_voltage_mv            = term_mv_ff;
  assign fast_charge_ma             = fast_ma_ff;
  assign input_limit_ma             = ilim_ma_ff;
  assign factory_ship_request       = ship_ff;
  assign thermal_foldback_threshold = thresh_ff;
  assign thermal_regulation_flag    = thermal_regulation_flag_ff;

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  sequence zone_write_s;
    reg_wr_en && reg_addr == `THERMAL_ZONE_CFG_OFS;
  endsequence

  sequence ilim_read_s;
    reg_rd_en && reg_addr == `INPUT_LIMIT_CFG_OFS;
  endsequence

  a_zone_off_passthru: assert property (
    !zone_en |=> term_voltage_mv == $past(primary_termination_voltage)
             && fast_charge_ma == $past(fast_charge_current_setting))
    else $error("Zone disabled but charge targets were modified.");

  a_cool_voltage_drop: assert property (
    (cool_active && zone_cfg_ff[`VREDUCE_BIT] && primary_termination_voltage >= REDUCE_MV)
      |=> term_voltage_mv == $past(primary_termination_voltage) - REDUCE_MV)
    else $error("Cool zone termination voltage not reduced by the cell figure.");

  a_cool_current_halve: assert property (
    (cool_active && zone_cfg_ff[`CHALVE_BIT])
      |=> fast_charge_ma == ($past(fast_charge_current_setting) >> 1))
    else $error("Cool zone fast-charge current not halved.");

  a_ship_write_effect: assert property (
    zone_write_s ##1 !reg_wr_en |=> factory_ship_request == $past(reg_wdata[`SHIP_BIT], 2))
    else $error("Ship mode request does not follow the written bit.");

  a_ilim_floor_code: assert property (
    eff_code < `ILIM_FLOOR_CODE |=> input_limit_ma == `ILIM_FLOOR_MA)
    else $error("Low input limit codes do not decode to the floor current.");

  a_ilim_step_code: assert property (
    eff_code >= `ILIM_FLOOR_CODE
      |=> input_limit_ma == ma_t'({5'h00, $past(eff_code)} * `ILIM_STEP_MA - `ILIM_STEP_MA))
    else $error("Input limit code decodes to the wrong step.");

  a_ilim_read_effective: assert property (
    ilim_read_s |=> reg_rd_valid && reg_rdata[`ILIM_MSB:`ILIM_LSB] == $past(eff_code))
    else $error("Input limit readback is not the limit in effect.");

  a_foldback_flag_set: assert property (
    die_temp_c > thresh_now |=> thermal_regulation_flag && thermal_foldback_threshold
                                == $past(thresh_now))
    else $error("Thermal regulation flag not set above the threshold.");

  a_unmapped_read_zero: assert property (
    reg_rd_en && reg_addr != `THERMAL_ZONE_CFG_OFS && reg_addr != `INPUT_LIMIT_CFG_OFS
      |=> reg_rdata == `UNMAPPED_READ_VAL)
    else $error("Unmapped read did not return zero.");
endmodule
`default_nettype wire

/* rtl/ilim_decode.sv */
// Input current limit code to milliamp decoder.
`include "charger_cfg_regs.svh"
`default_nettype none
module ilim_decode (
  // Limit code.
  input  wire charger_cfg_pkg::ilim_code_t code,
  // Decoded limit.
  output var  charger_cfg_pkg::ma_t        limit_ma
);
  import charger_cfg_pkg::*;

  ma_t code_wide;

  always_comb begin
    code_wide = {5'h00, code};
    if (code < `ILIM_FLOOR_CODE) begin
      limit_ma = `ILIM_FLOOR_MA;
    end else begin
      limit_ma = ma_t'(code_wide * `ILIM_STEP_MA - `ILIM_STEP_MA);
    end
  end
endmodule
`default_nettype wire

/* tb/charger_thermal_input_limit_cfg_tb_top.sv */
// Self-checking bench for the charger thermal-zone and input limit registers.
`default_nettype none
module charger_thermal_input_limit_cfg_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  import charger_cfg_pkg::*;
  logic       clk, rst_b, reg_wr_en, reg_rd_en, reg_rd_valid, cool, ovr_valid, ship, flag, en;
  reg_addr_t  reg_addr;
  reg_data_t  reg_wdata, reg_rdata, last8;
  mv_t        prim, term;
  ma_t        fcc, fcc_out, ilim_ma;
  temp_c_t    die, thr, thr_exp;
  ilim_code_t ovr_code, code;
  int         seed, n_errors, samples_checked;
  logic [31:0] rnd;
  reg_data_t  exp_q[$];
  reg_data_t  zcfg [6] = '{8'h86, 8'h06, 8'h80, 8'h86, 8'h84, 8'h82};
  logic       zcool [6] = '{1'b1, 1'b1, 1'b1, 1'b0, 1'b1, 1'b1};

  host_bus_model i_host_bus_model (.clk(clk), .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata));
  charger_thermal_input_limit_cfg i_charger_thermal_input_limit_cfg (.clk(clk), .rst_b(rst_b),
    .reg_wr_en(reg_wr_en), .reg_rd_en(reg_rd_en), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .reg_rd_valid(reg_rd_valid), .primary_termination_voltage(prim),
    .fast_charge_current_setting(fcc), .thermistor_cool_zone(cool), .die_temp_c(die),
    .ilim_override_valid(ovr_valid), .ilim_override_code(ovr_code), .term_voltage_mv(term),
    .fast_charge_ma(fcc_out), .input_limit_ma(ilim_ma), .factory_ship_request(ship),
    .thermal_foldback_threshold(thr), .thermal_regulation_flag(flag));

  initial begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic wr(input reg_addr_t a, input reg_data_t d);
    i_host_bus_model.xfer(1'b1, a, d);
    repeat (3) @(negedge clk);
  endtask
  task automatic rd(input reg_addr_t a, input reg_data_t exp);
    exp_q.push_back(exp);
    i_host_bus_model.xfer(1'b0, a, 8'h00);
    @(negedge clk);
  endtask
  function automatic ma_t ilim_exp(input ilim_code_t c);
    return (c < 7'h04) ? 12'h032 : 12'(12'h019 * (12'(c) - 12'h001));
  endfunction
  task automatic end_of_test();
    // A read whose answer never came leaves its note behind.
    check(16'(exp_q.size()), 16'h0000);
    $display("checks %0d mismatches %0d", samples_checked, n_errors);
    if (n_errors == 0 && samples_checked > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Each read result is matched against the oldest expectation noted by the reader.
  always @(negedge clk) begin
    if (reg_rd_valid === 1'b1) begin
      if (exp_q.size() == 0) check(16'hFFFF, 16'h0000);
      else check({8'h00, reg_rdata}, {8'h00, exp_q.pop_front()});
    end
  end

  initial begin
    #20000;
    n_errors++;
    end_of_test();
  end

  initial begin
    seed = 48;
    n_errors = 0;
    samples_checked = 0;
    rst_b = 1'b0;
    prim = 16'h20D0;
    fcc = 12'h3E8;
    cool = 1'b0;
    die = 8'h00;
    ovr_valid = 1'b0;
    ovr_code = 7'h00;
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    rd(8'h1D, 8'h32);
    rd(8'h1E, 8'h95);
    rd(8'h20, 8'h00);
    $display("reset values done");
    for (int j = 1; j >= 0; j--) begin
      wr(8'h1D, 8'(j));
      check({15'h0000, ship}, 16'(j));
      rd(8'h1D, 8'(j));
    end
    $display("ship mode done");
    for (int i = 0; i < 6; i++) begin
      rnd = $random(seed);
      prim = 16'h1000 + 16'(rnd[11:0]);
      fcc = rnd[27:16];
      cool = zcool[i];
      wr(8'h1D, zcfg[i]);
      repeat (2) @(negedge clk);
      en = zcfg[i][7] & cool;
      check(term, prim - ((en & zcfg[i][2]) ? 16'h0168 : 16'h0000));
      check({4'h0, fcc_out}, {4'h0, fcc >> (en & zcfg[i][1])});
    end
    $display("zone adjust done");
    for (int i = 0; i < 4; i++) begin
      rnd = $random(seed);
      code = (i == 0) ? 7'h00 : ((i == 1) ? 7'h0F : 7'(rnd[3:0]));
      wr(8'h1D, {1'b0, code[3:0], 3'h0});
      thr_exp = 8'h55 + 8'h05 * 8'(code[3:0]);
      check({8'h00, thr}, {8'h00, thr_exp});
      die = thr_exp;
      repeat (2) @(negedge clk);
      check({15'h0000, flag}, 16'h0000);
      die = thr_exp + 8'h01;
      repeat (2) @(negedge clk);
      check({15'h0000, flag}, 16'h0001);
    end
    $display("thermal foldback done");
    for (int i = 0; i < 10; i++) begin
      rnd = $random(seed);
      code = (i < 8) ? 7'(i) : ((i == 8) ? 7'h7F : 7'(rnd));
      last8 = {rnd[8], code};
      wr(8'h1E, last8);
      check({4'h0, ilim_ma}, {4'h0, ilim_exp(code)});
      rd(8'h1E, last8);
    end
    $display("input limit decode done");
    rnd = $random(seed);
    ovr_code = 7'(rnd);
    ovr_valid = 1'b1;
    repeat (2) @(negedge clk);
    check({4'h0, ilim_ma}, {4'h0, ilim_exp(ovr_code)});
    rd(8'h1E, {last8[7], ovr_code});
    ovr_valid = 1'b0;
    repeat (2) @(negedge clk);
    rd(8'h1E, last8);
    repeat (2) @(negedge clk);
    $display("effective limit readback done");
    end_of_test();
  end
endmodule
`default_nettype wire

/* tb/host_bus_model.sv */
// Host processor model that issues register reads and writes on the strobe port.
`default_nettype none
module host_bus_model (
  // Clock.
  input  wire logic                       clk,
  // Register strobe port.
  output var  logic                       reg_wr_en,
  output var  logic                       reg_rd_en,
  output var  charger_cfg_pkg::reg_addr_t reg_addr,
  output var  charger_cfg_pkg::reg_data_t reg_wdata
);
  timeunit 1ns;
  timeprecision 1ps;
  import charger_cfg_pkg::*;
  initial begin
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr  = 8'h00;
    reg_wdata = 8'h00;
  end
  // Idle address and data are inverted so that a stale value is never mistaken for a live one.
  task automatic xfer(input logic wr, input reg_addr_t a, input reg_data_t d);
    @(negedge clk);
    reg_wr_en = wr;
    reg_rd_en = ~wr;
    reg_addr  = a;
    reg_wdata = d;
    @(negedge clk);
    reg_wr_en = 1'b0;
    reg_rd_en = 1'b0;
    reg_addr  = ~a;
    reg_wdata = ~d;
  endtask
endmodule
`default_nettype wire
